// File: common/raac_pkg.sv
// Package with register map, field positions, timing counts and states of the auto-ack receive control.
package raac_pkg;
	// ==================================================================
	// Register map
	localparam logic [5:0] EXT_CTRL_ONE_ADDR = 6'h17;
	localparam logic [5:0] EXT_CTRL_ZERO_ADDR = 6'h2c;
	localparam logic [7:0] EXT_CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] EXT_CTRL_ZERO_RST = 8'h00;

	// ==================================================================
	// Field positions
	localparam int SHORT_ACK_DELAY_BIT = 2;
	localparam int RESERVED_TYPE_UPLOAD_BIT = 4;
	localparam int RESERVED_TYPE_FILTER_BIT = 5;
	localparam int SLOTTED_OPERATION_BIT = 0;

	// ==================================================================
	// Acknowledgement delays in symbol periods
	localparam logic [3:0] ACK_DELAY_STD_SYM = 4'hc;
	localparam logic [3:0] ACK_DELAY_SHORT_A_SYM = 4'h2;
	localparam logic [3:0] ACK_DELAY_SHORT_B_SYM = 4'h3;
	localparam logic [3:0] SLOT_ENABLE_STD_SYM = 4'h6;
	localparam logic [3:0] SLOT_ENABLE_SHORT_SYM = 4'h3;

	// ==================================================================
	// Transaction status codes
	localparam logic [2:0] TRAC_SUCCESS = 3'h0;
	localparam logic [2:0] TRAC_WAIT_FOR_ACK = 3'h2;
	localparam logic [2:0] TRAC_INVALID = 3'h7;

	// ==================================================================
	// Receive states, one-hot
	typedef enum logic [5:0] {
		ST_LISTEN = 6'h01,
		ST_LISTEN_NOCLK = 6'h02,
		ST_BUSY = 6'h04,
		ST_BUSY_NOCLK = 6'h08,
		ST_ACK_WAIT = 6'h10,
		ST_ACK_TX = 6'h20
	} raac_state_e;
endpackage : raac_pkg

// File: core/raac_ctrl.sv
// Auto-acknowledge receive control: reserved frame types, ack timing, no-clock listening, slotted ack.
`timescale 1ns/1ps
`default_nettype none
module raac_ctrl
	import raac_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	input wire logic sleep_trigger_pin,
	input wire logic symbol_tick,
	input wire logic phy_group_b,
	input wire logic sfd_detect,
	input wire logic frame_done,
	input wire logic frame_reserved_type,
	input wire logic frame_addr_match,
	input wire logic frame_fcs_valid,
	input wire logic frame_ack_request,
	input wire logic ack_tx_done,
	output logic frame_end_irq,
	output logic address_match_irq,
	output logic ack_tx_start,
	output logic clock_output_pin_en,
	output logic [2:0] transaction_status,
	output logic [5:0] trx_state
);

	// ==================================================================
	// Register file
	logic [7:0] extended_ctrl_one_r;
	logic [7:0] extended_ctrl_zero_r;
	logic [7:0] reg_rdata_r;
	logic reserved_type_upload;
	logic reserved_type_filter;
	logic short_ack_delay;
	logic slotted_mode;

	// Software writes land at the two documented offsets; other offsets are not held here.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			extended_ctrl_one_r <= EXT_CTRL_ONE_RST;
			extended_ctrl_zero_r <= EXT_CTRL_ZERO_RST;
		end else if (reg_we) begin
			if (reg_addr == EXT_CTRL_ONE_ADDR) begin
				extended_ctrl_one_r <= reg_wdata;
			end
			if (reg_addr == EXT_CTRL_ZERO_ADDR) begin
				extended_ctrl_zero_r <= reg_wdata;
			end
		end
	end

	// Reads answer one cycle later; unmapped offsets read as zero.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_re) begin
			case (reg_addr)
				EXT_CTRL_ONE_ADDR: reg_rdata_r <= extended_ctrl_one_r;
				EXT_CTRL_ZERO_ADDR: reg_rdata_r <= extended_ctrl_zero_r;
				default: reg_rdata_r <= 8'h00;
			endcase
		end
	end

	// Read data and control fields come straight from the register flops.
	assign reg_rdata = reg_rdata_r;
	assign reserved_type_upload = extended_ctrl_one_r[RESERVED_TYPE_UPLOAD_BIT];
	assign reserved_type_filter = extended_ctrl_one_r[RESERVED_TYPE_FILTER_BIT];
	assign short_ack_delay = extended_ctrl_one_r[SHORT_ACK_DELAY_BIT];
	assign slotted_mode = extended_ctrl_zero_r[SLOTTED_OPERATION_BIT];

	// ==================================================================
	// Trigger pin synchroniser and edge detection
	logic trig_meta_r;
	logic trig_sync_r;
	logic trig_prev_r;
	logic trig_rise;
	logic trig_fall;

	// The pin is asynchronous to mclk, so only the second stage feeds the edge detector.
	// A third flop keeps the previous level for edge detection.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			trig_meta_r <= 1'b0;
			trig_sync_r <= 1'b0;
			trig_prev_r <= 1'b0;
		end else begin
			trig_meta_r <= sleep_trigger_pin;
			trig_sync_r <= trig_meta_r;
			trig_prev_r <= trig_sync_r;
		end
	end

	// The previous stage resets low like the idle pin, so no false edge follows reset.
	assign trig_rise = trig_sync_r && !trig_prev_r;
	assign trig_fall = !trig_sync_r && trig_prev_r;

	// ==================================================================
	// Frame verdict at frame end
	logic frame_accept;
	logic frame_ami;
	logic frame_ack;
	logic reserved_bypass;

	// A bypassed reserved frame skips the address filter and is never acknowledged.
	assign reserved_bypass = frame_reserved_type && reserved_type_upload
		&& !reserved_type_filter;

	// Verdict for the frame that ends this cycle; it is only read while frame_done is high.
	always_comb begin
		if (frame_reserved_type && !reserved_type_upload) begin
			frame_accept = 1'b0;
			frame_ami = 1'b0;
		end else if (reserved_bypass) begin
			frame_accept = frame_fcs_valid;
			frame_ami = 1'b0;
		end else begin
			frame_accept = frame_addr_match && frame_fcs_valid;
			frame_ami = frame_addr_match;
		end
		frame_ack = frame_accept && frame_ack_request && !reserved_bypass;
	end

	// ==================================================================
	// Acknowledgement delay selection
	logic [3:0] ack_delay_sym;

	// Applies regardless of upload, filter or promiscuous settings.
	// In slotted mode the value is the earliest trigger point, not a start delay.
	always_comb begin
		if (slotted_mode) begin
			ack_delay_sym = short_ack_delay ? SLOT_ENABLE_SHORT_SYM
				: SLOT_ENABLE_STD_SYM;
		end else if (!short_ack_delay) begin
			ack_delay_sym = ACK_DELAY_STD_SYM;
		end else begin
			ack_delay_sym = phy_group_b ? ACK_DELAY_SHORT_B_SYM
				: ACK_DELAY_SHORT_A_SYM;
		end
	end

	// ==================================================================
	// State decode helpers
	// Both listening states take a start delimiter; both busy states judge a frame.
	function automatic logic is_listen_state(input raac_state_e st);
		is_listen_state = (st == ST_LISTEN) || (st == ST_LISTEN_NOCLK);
	endfunction : is_listen_state

	function automatic logic is_busy_state(input raac_state_e st);
		is_busy_state = (st == ST_BUSY) || (st == ST_BUSY_NOCLK);
	endfunction : is_busy_state

	// The clock output is stopped only in the two no-clock states.
	function automatic logic is_noclk_state(input raac_state_e st);
		is_noclk_state = (st == ST_LISTEN_NOCLK) || (st == ST_BUSY_NOCLK);
	endfunction : is_noclk_state

	// ==================================================================
	// Receive state machine
	raac_state_e state_r;
	raac_state_e state_nxt;
	logic [3:0] sym_cnt_r;
	logic delay_done;

	// The slotted window only opens once the count reaches the enable delay.
	assign delay_done = (sym_cnt_r >= ack_delay_sym);

	// Next state. A start delimiter wins over a same-cycle trigger edge, so no frame is lost.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_LISTEN: begin
				if (sfd_detect) begin
					state_nxt = ST_BUSY;
				end else if (trig_rise && !slotted_mode) begin
					state_nxt = ST_LISTEN_NOCLK;
				end
			end
			ST_LISTEN_NOCLK: begin
				// Setting slotted operation here forces a return: no-clock is not offered then.
				if (sfd_detect) begin
					state_nxt = ST_BUSY_NOCLK;
				end else if (trig_fall || slotted_mode) begin
					state_nxt = ST_LISTEN;
				end
			end
			ST_BUSY: begin
				if (frame_done) begin
					state_nxt = frame_ack ? ST_ACK_WAIT : ST_LISTEN;
				end
			end
			ST_BUSY_NOCLK: begin
				if (frame_done) begin
					if (frame_ack) begin
						state_nxt = ST_ACK_WAIT;
					end else if (frame_accept) begin
						state_nxt = ST_LISTEN;
					end else if (trig_fall || slotted_mode) begin
						state_nxt = ST_LISTEN;
					end else begin
						state_nxt = ST_LISTEN_NOCLK;
					end
				end else if (trig_fall || slotted_mode) begin
					state_nxt = ST_BUSY;
				end
			end
			ST_ACK_WAIT: begin
				// An early trigger edge is not latched, so the host must respect the window.
				if (slotted_mode) begin
					if (delay_done && trig_rise) begin
						state_nxt = ST_ACK_TX;
					end
				end else if (delay_done) begin
					state_nxt = ST_ACK_TX;
				end
			end
			ST_ACK_TX: begin
				// No timeout here: the transmitter must always report ack_tx_done.
				if (ack_tx_done) begin
					state_nxt = ST_LISTEN;
				end
			end
			default: state_nxt = ST_LISTEN;
		endcase
	end

	// State register; reset lands in normal listening with the clock output running.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_r <= ST_LISTEN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Symbol counter runs only while an acknowledgement is pending, saturating at its top.
	// Four bits cover the longest count needed, twelve symbols.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sym_cnt_r <= 4'h0;
		end else if (state_r != ST_ACK_WAIT) begin
			sym_cnt_r <= 4'h0;
		end else if (symbol_tick && sym_cnt_r != 4'hf) begin
			sym_cnt_r <= sym_cnt_r + 4'h1;
		end
	end

	// ==================================================================
	// Event outputs, one-cycle pulses
	logic frame_end_irq_r;
	logic address_match_irq_r;
	logic ack_tx_start_r;
	logic frame_eval;

	// A frame is judged only when it ends in one of the two busy states.
	assign frame_eval = frame_done && is_busy_state(state_r);

	// Pulses are registered so every event output comes straight from a flip-flop.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			frame_end_irq_r <= 1'b0;
			address_match_irq_r <= 1'b0;
			ack_tx_start_r <= 1'b0;
		end else begin
			frame_end_irq_r <= frame_eval && frame_accept;
			address_match_irq_r <= frame_eval && frame_ami;
			ack_tx_start_r <= (state_r == ST_ACK_WAIT) && (state_nxt == ST_ACK_TX);
		end
	end

	// ==================================================================
	// Clock output enable and status
	logic clk_out_en_r;
	logic [2:0] transaction_status_r;

	// The clock follows the next state so it is back before frame end is serviced.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			clk_out_en_r <= 1'b1;
		end else begin
			clk_out_en_r <= !is_noclk_state(state_nxt);
		end
	end

	// Status starts invalid on each new frame and shows the wait code while ack is pending.
	// The wait code has priority, so a slotted wait keeps showing it until the trigger.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			transaction_status_r <= TRAC_INVALID;
		end else if (state_nxt == ST_ACK_WAIT) begin
			transaction_status_r <= TRAC_WAIT_FOR_ACK;
		end else if (sfd_detect && is_listen_state(state_r)) begin
			transaction_status_r <= TRAC_INVALID;
		end else if (frame_eval && frame_accept) begin
			transaction_status_r <= TRAC_SUCCESS;
		end else if (state_r == ST_ACK_TX && ack_tx_done) begin
			transaction_status_r <= TRAC_SUCCESS;
		end
	end

	logic [5:0] trx_state_r;

	// State as seen outside; taken from the next state so it always equals state_r.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			trx_state_r <= ST_LISTEN;
		end else begin
			trx_state_r <= state_nxt;
		end
	end

	// Every port is driven straight from its flip-flop.
	assign frame_end_irq = frame_end_irq_r;
	assign address_match_irq = address_match_irq_r;
	assign ack_tx_start = ack_tx_start_r;
	assign clock_output_pin_en = clk_out_en_r;
	assign transaction_status = transaction_status_r;
	assign trx_state = trx_state_r;
endmodule : raac_ctrl
`default_nettype wire

// File: tb/raac_ctrl_properties.sv
// Concurrent checks on the auto-ack receive control ports.
`timescale 1ns/1ps
`default_nettype none
module raac_ctrl_properties
	import raac_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic frame_done,
	input wire logic frame_reserved_type,
	input wire logic frame_addr_match,
	input wire logic frame_fcs_valid,
	input wire logic frame_ack_request,
	input wire logic frame_end_irq,
	input wire logic address_match_irq,
	input wire logic ack_tx_start,
	input wire logic clock_output_pin_en,
	input wire logic [2:0] transaction_status,
	input wire logic [5:0] trx_state
);
	// ==================================================================
	// Shadow registers
	logic [7:0] one_r;
	logic slot_r;
	// Shadows follow the writes, so the mode-dependent checks know the setting.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			one_r <= 8'h00;
			slot_r <= 1'b0;
		end else if (reg_we && reg_addr == EXT_CTRL_ONE_ADDR) begin
			one_r <= reg_wdata;
		end else if (reg_we && reg_addr == EXT_CTRL_ZERO_ADDR) begin
			slot_r <= reg_wdata[0];
		end
	end
	// ==================================================================
	// Properties
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_bypass;
		frame_done && frame_reserved_type && one_r[4] && !one_r[5];
	endsequence
	sequence s_accept;
		frame_done && !frame_reserved_type && frame_addr_match && frame_fcs_valid
			&& frame_ack_request && trx_state == ST_BUSY;
	endsequence
	a_bypass_no_ack: assert property (s_bypass |=> !address_match_irq && trx_state != ST_ACK_WAIT)
		else $error("bypassed frame matched or acknowledged");
	a_discard_reserved: assert property (frame_done && frame_reserved_type && !one_r[4] |=> !frame_end_irq)
		else $error("discarded frame raised frame end");
	a_accept_to_wait: assert property (s_accept |=> trx_state == ST_ACK_WAIT && frame_end_irq)
		else $error("accepted frame did not wait for ack");
	a_noclk_stops: assert property (trx_state == ST_LISTEN_NOCLK |-> !clock_output_pin_en)
		else $error("clock output runs in no-clock listen");
	a_listen_clock: assert property (trx_state == ST_LISTEN |-> clock_output_pin_en)
		else $error("clock output stopped in listen");
	a_slotted_noclk: assert property (slot_r [*3] |-> trx_state != ST_LISTEN_NOCLK)
		else $error("no-clock listen while slotted");
	a_wait_status: assert property (trx_state == ST_ACK_WAIT |-> transaction_status == TRAC_WAIT_FOR_ACK)
		else $error("wrong status while waiting");
	a_ack_after_wait: assert property (ack_tx_start |-> $past(trx_state) == ST_ACK_WAIT)
		else $error("ack started outside ack wait");
endmodule : raac_ctrl_properties
bind raac_ctrl raac_ctrl_properties chk_i (.*);
`default_nettype wire

// File: tb/raac_host_model.sv
// Host model that drives the sleep/trigger pin, including the slotted ack edge.
`timescale 1ns/1ps
`default_nettype none
module raac_host_model (
	input wire logic mclk,
	input wire logic symbol_tick,
	input wire logic frame_end_irq,
	input wire logic slot_go,
	input wire logic pin_lvl,
	output logic sleep_trigger_pin
);
	logic [3:0] cnt_r = 4'h0;
	logic arm_r = 1'b0;
	logic fire_r = 1'b0;
	// Waits four symbols after frame end, one spare over the minimum, then pulses the pin.
	always_ff @(posedge mclk) begin
		if (!slot_go) begin
			arm_r <= 1'b0;
			fire_r <= 1'b0;
		end else if (frame_end_irq) begin
			arm_r <= 1'b1;
			cnt_r <= 4'h0;
		end else if (symbol_tick && fire_r) begin
			fire_r <= 1'b0;
		end else if (symbol_tick && arm_r) begin
			cnt_r <= cnt_r + 4'h1;
			arm_r <= cnt_r != 4'h3;
			fire_r <= cnt_r == 4'h3;
		end
	end
	assign sleep_trigger_pin = pin_lvl | fire_r;
endmodule : raac_host_model
`default_nettype wire

// File: tb/testbench.sv
// Testbench for the auto-ack receive control.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import raac_pkg::*;
;
	logic mclk = 0, reset_n = 0, reg_we = 0, reg_re = 0, symbol_tick = 0, phy_group_b = 0;
	logic sfd_detect = 0, frame_done = 0, frame_reserved_type = 0, frame_addr_match = 0;
	logic frame_fcs_valid = 0, frame_ack_request = 0, ack_tx_done = 0, slot_go = 0, pin_lvl = 0;
	logic sleep_trigger_pin, frame_end_irq, address_match_irq, ack_tx_start, clock_output_pin_en;
	logic [5:0] reg_addr = 0, trx_state;
	logic [7:0] reg_wdata = 0, reg_rdata;
	logic [2:0] transaction_status;
	logic [1:0] tc = 0;
	int num_errors = 0, n_compared = 0, nt;
	raac_ctrl raac_ctrl_i (.*);
	raac_host_model raac_host_model_i (.*);
	// ==================================================================
	// Clock and symbol ticks
	always #2.5 mclk = ~mclk;
	// A tick every fourth cycle keeps counted symbols apart from edge slop.
	always @(posedge mclk) begin
		#1;
		tc = tc + 2'h1;
		symbol_tick = tc == 2'h3;
	end
	// ==================================================================
	// Tasks
	task automatic tk(int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tk
	task automatic test_done();
		if (num_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(logic [5:0] a, logic [7:0] d);
		tk();
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1;
		tk();
		reg_we = 0;
	endtask : wr
	task automatic rd(logic [5:0] a, logic [7:0] e);
		tk();
		reg_addr = a;
		reg_re = 1;
		tk();
		reg_re = 0;
		chk(reg_rdata, e);
	endtask : rd
	// Frame qualifiers are set in the frame_done cycle and held until the next frame sets them.
	task automatic frame(logic [3:0] q);
		tk();
		sfd_detect = 1;
		tk();
		sfd_detect = 0;
		tk(2);
		{frame_reserved_type, frame_addr_match, frame_fcs_valid, frame_ack_request} = q;
		frame_done = 1;
		tk();
		frame_done = 0;
	endtask : frame
	// Counts symbols spent in ack wait until the ack starts, then finishes it.
	task automatic wait_ack();
		nt = 0;
		for (int i = 0; i < 300 && ack_tx_start !== 1'b1; i++) begin
			@(posedge mclk);
			// Read before this edge's updates land: the same pair the symbol counter samples.
			if (symbol_tick && trx_state === ST_ACK_WAIT) nt++;
			#1;
		end
		if (ack_tx_start !== 1'b1) begin
			num_errors++;
			test_done();
		end else begin
			ack_tx_done = 1;
			tk();
			ack_tx_done = 0;
			tk();
			chk({trx_state, transaction_status}, {ST_LISTEN, TRAC_SUCCESS});
		end
	endtask : wait_ack
	// ==================================================================
	// Main sequence
	initial begin
		tk(10);
		reset_n = 1;
		chk({trx_state, clock_output_pin_en}, {ST_LISTEN, 1'b1});
		chk(transaction_status, TRAC_INVALID);
		rd(EXT_CTRL_ONE_ADDR, 8'h00);
		rd(EXT_CTRL_ZERO_ADDR, 8'h00);
		rd(6'h3f, 8'h00);
		frame(4'hf);
		chk(frame_end_irq, 0);
		tk(20);
		chk(trx_state, ST_LISTEN);
		wr(EXT_CTRL_ONE_ADDR, 8'h10);
		rd(EXT_CTRL_ONE_ADDR, 8'h10);
		frame(4'hb);
		chk({frame_end_irq, address_match_irq}, 2'b10);
		tk(20);
		chk(trx_state, ST_LISTEN);
		wr(EXT_CTRL_ONE_ADDR, 8'h30);
		frame(4'hb);
		chk(frame_end_irq, 0);
		frame(4'hf);
		chk({frame_end_irq, address_match_irq}, 2'b11);
		wait_ack();
		chk(nt[15:0], 16'h000c);
		wr(EXT_CTRL_ONE_ADDR, 8'h34);
		for (int g = 0; g < 2; g++) begin
			phy_group_b = g[0];
			frame(4'hf);
			wait_ack();
			chk(nt[15:0], 16'(2 + g));
		end
		wr(EXT_CTRL_ONE_ADDR, 8'h00);
		pin_lvl = 1;
		tk(6);
		chk({trx_state, clock_output_pin_en}, {ST_LISTEN_NOCLK, 1'b0});
		frame(4'h7);
		chk(clock_output_pin_en, 1);
		wait_ack();
		tk(6);
		chk(trx_state, ST_LISTEN);
		pin_lvl = 0;
		tk(6);
		pin_lvl = 1;
		tk(6);
		chk(trx_state, ST_LISTEN_NOCLK);
		pin_lvl = 0;
		tk(6);
		chk({trx_state, clock_output_pin_en}, {ST_LISTEN, 1'b1});
		pin_lvl = 1;
		tk(6);
		frame(4'h6);
		chk({frame_end_irq, trx_state, clock_output_pin_en}, {1'b1, ST_LISTEN, 1'b1});
		pin_lvl = 0;
		wr(EXT_CTRL_ZERO_ADDR, 8'h01);
		rd(EXT_CTRL_ZERO_ADDR, 8'h01);
		pin_lvl = 1;
		tk(6);
		chk(trx_state, ST_LISTEN);
		pin_lvl = 0;
		wr(EXT_CTRL_ONE_ADDR, 8'h04);
		slot_go = 1;
		frame(4'h7);
		pin_lvl = 1;
		tk(2);
		pin_lvl = 0;
		tk(8);
		chk({trx_state, transaction_status}, {ST_ACK_WAIT, TRAC_WAIT_FOR_ACK});
		wait_ack();
		test_done();
	end
endmodule : testbench
`default_nettype wire
